// ==== core/tw_cfg.svh ====
// constants for the two-wire bus interface: register offsets, field positions, timing
// assumes a 125 MHz system clock and a classic wishbone slave port with 32-bit words
`ifndef TW_CFG_SVH
`define TW_CFG_SVH
// register byte offsets
`define TW_OFS_CTRL    4'h0
`define TW_OFS_STAT1   4'h4
`define TW_OFS_STAT2   4'h8
`define TW_OFS_DATA    4'hC
`define TW_OFS_OWNA1   5'h10
`define TW_OFS_OWNA2   5'h14
// control register fields
`define TW_CR_IRQ      0
`define TW_CR_ACK      1
`define TW_CR_STOP     2
`define TW_CR_START    3
`define TW_CR_ENGC     4
`define TW_CR_PE       5
// own address two fields
`define TW_OA2_ADD10   0
`define TW_OA2_ADDHI   2
`define TW_OA2_FR      6
// reset values
`define TW_CR_RST      8'h00
`define TW_OA_RST      8'h00
// timing: system clock and bus rates
`define TW_CLK_HZ      125000000
`define TW_STD_HZ      100000
`define TW_FAST_HZ     400000
// half period counts of the bus clock, rounded up so the rate never exceeds the limit
`define TW_STD_HALF    ((`TW_CLK_HZ + 2 * `TW_STD_HZ - 1) / (2 * `TW_STD_HZ))
`define TW_FAST_HALF   ((`TW_CLK_HZ + 2 * `TW_FAST_HZ - 1) / (2 * `TW_FAST_HZ))
`define TW_GC_ADDR     8'h00
`define TW_HDR_PAT     5'h1E
`endif

// ==== core/tw_pkg.sv ====
// types for the two-wire bus interface
// assumes tw_cfg.svh supplies the numeric constants
`default_nettype none
package tw_pkg;
    // decoded bus conditions from the line watcher
    typedef struct packed {
        logic start;    // start or repeated start seen
        logic stop;     // stop seen
        logic sclRise;  // clock rising edge
        logic sclFall;  // clock falling edge
        logic sda;      // synchronised data level
    } tw_cond_t;
    // slave engine states
    typedef enum logic [2:0] {
        TW_IDLE, TW_ADDR, TW_ACKA, TW_RX, TW_ACKR, TW_TX, TW_ACKT, TW_HOLD
    } tw_state_t;
endpackage
`default_nettype wire

// ==== core/tw_line_watch.sv ====
// pin synchroniser and start/stop/edge detector for the data and clock lines
// assumes both pins are asynchronous to clk
`default_nettype none
module tw_line_watch
    import tw_pkg::*;
(
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic serialDataPin,
    input  wire logic serialClockPin,
    output tw_cond_t  cond
);
    logic [1:0] sdaSync_r;  // two-stage synchroniser, data
    logic [1:0] sclSync_r;  // two-stage synchroniser, clock
    logic       sdaOld_r;   // previous synchronised data level
    logic       sclOld_r;   // previous synchronised clock level

    // only the second stage is ever read by logic
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sdaSync_r <= 2'h3;
            sclSync_r <= 2'h3;
            sdaOld_r  <= 1'b1;
            sclOld_r  <= 1'b1;
        end else begin
            sdaSync_r <= {sdaSync_r[0], serialDataPin};
            sclSync_r <= {sclSync_r[0], serialClockPin};
            sdaOld_r  <= sdaSync_r[1];
            sclOld_r  <= sclSync_r[1];
        end
    end

    // data changing while clock high marks start or stop
    always_comb begin
        cond.start   = sclSync_r[1] && sclOld_r && sdaOld_r && !sdaSync_r[1];
        cond.stop    = sclSync_r[1] && sclOld_r && !sdaOld_r && sdaSync_r[1];
        cond.sclRise = sclSync_r[1] && !sclOld_r;
        cond.sclFall = !sclSync_r[1] && sclOld_r;
        cond.sda     = sdaSync_r[1];
    end
endmodule
`default_nettype wire

// ==== core/tw_clk_div.sv ====
// bus clock rate divider: one-cycle tick per bus clock half period
// assumes clk at the rate in tw_cfg.svh; restarts while not running
`include "tw_cfg.svh"
`default_nettype none
module tw_clk_div
    import tw_pkg::*;
(
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic run,
    input  wire logic fastMode,
    output logic      halfTick
);
    logic [9:0] cnt_r;   // half period counter
    logic [9:0] limit;   // selected terminal count

    // mode picks the terminal count
    always_comb begin
        limit = fastMode ? 10'(`TW_FAST_HALF - 1) : 10'(`TW_STD_HALF - 1);
    end

    // free counter while the master clock runs
    always_ff @(posedge clk) begin
        if (sys_rst || !run) begin
            cnt_r    <= 10'h000;
            halfTick <= 1'b0;
        end else if (cnt_r >= limit) begin
            cnt_r    <= 10'h000;
            halfTick <= 1'b1;
        end else begin
            cnt_r    <= cnt_r + 10'h001;
            halfTick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== core/tw_iface.sv ====
// two-wire bus interface: wishbone register slave, slave engine, role and flag logic
// assumes classic wishbone on clk, pins come in asynchronously, open-drain pads outside
`include "tw_cfg.svh"
`default_nettype none
module tw_iface
    import tw_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [4:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic             wb_ack_o,
    input  wire logic        serial_data_pin,
    input  wire logic        serial_clock_pin,
    output logic             sdaOe,
    output logic             sclOe,
    output logic             pinsOwned,
    output logic             irq
);
    tw_cond_t   cond;            // decoded line conditions
    tw_state_t  state_r;         // slave engine state
    logic [7:0] control_reg;     // control bits
    logic [7:0] ownAddrOne_r;    // own address low byte
    logic [7:0] own_address_two_reg; // speed, mode, address high bits
    logic [7:0] byte_buffer_reg; // data byte seen by software
    logic [7:0] shift_r;         // bus shift register
    logic [3:0] bitCnt_r;        // bits of current byte
    logic       event_flag;
    logic       own_address_match_flag;
    logic       byte_done_flag;
    logic       bus_end_seen_flag;
    logic       misplaced_condition_error;
    logic       nack_failure_flag;
    logic       busy_r;          // bus busy
    logic       controller_role_bit; // master role
    logic       txMode_r;        // slave transmitter
    logic       gcHit_r;         // general call matched
    logic       hdrSeen_r;       // full ten-bit address (header and second byte) already matched once
    logic       secondByte_r;    // next address byte is ten-bit second byte
    logic       st1Seen_r;       // status one read since last data access
    logic       stretch_r;       // holding clock low
    logic       txPend_r;        // transmitter owed a data write
    logic       sdaDrv_r;        // drive data low
    logic       halfTick;        // divider tick (master clock)
    logic       wbHit;           // valid wishbone strobe this cycle
    logic       rdSt1, rdSt2, rdData, wrData, wrCtrl; // register side effects
    logic       ten;             // ten-bit addressing selected
    logic       enabled;         // peripheral enable

    tw_line_watch uWatch (
        .clk            (clk),
        .sys_rst        (sys_rst),
        .serialDataPin  (serial_data_pin),
        .serialClockPin (serial_clock_pin),
        .cond           (cond)
    );

    // master clock divider; runs only in the master role
    tw_clk_div uDiv (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .run      (controller_role_bit),
        .fastMode (own_address_two_reg[`TW_OA2_FR]),
        .halfTick (halfTick)
    );

    assign ten     = own_address_two_reg[`TW_OA2_ADD10];
    assign enabled = control_reg[`TW_CR_PE];
    assign wbHit   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign rdSt1   = wbHit && !wb_we_i && wb_adr_i == 5'(`TW_OFS_STAT1);
    assign rdSt2   = wbHit && !wb_we_i && wb_adr_i == 5'(`TW_OFS_STAT2);
    assign rdData  = wbHit && !wb_we_i && wb_adr_i == 5'(`TW_OFS_DATA);
    assign wrData  = wbHit && wb_we_i && wb_sel_i[0] && wb_adr_i == 5'(`TW_OFS_DATA);
    assign wrCtrl  = wbHit && wb_we_i && wb_sel_i[0] && wb_adr_i == 5'(`TW_OFS_CTRL);

    // one registered ack per access, a cycle after the strobe; ack drops the cycle after
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wbHit;
        end
    end

    // read mux; unmapped offsets read zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wbHit && !wb_we_i) begin
            case (wb_adr_i)
                5'(`TW_OFS_CTRL):  wb_dat_o <= {24'h0, control_reg};
                5'(`TW_OFS_STAT1): wb_dat_o <= {24'h0, event_flag, 1'b0, txMode_r, busy_r,
                                    byte_done_flag, own_address_match_flag,
                                    controller_role_bit, 1'b0};
                5'(`TW_OFS_STAT2): wb_dat_o <= {26'h0, gcHit_r, 1'b0, nack_failure_flag,
                                    bus_end_seen_flag, 1'b0, misplaced_condition_error};
                5'(`TW_OFS_DATA):  wb_dat_o <= {24'h0, byte_buffer_reg};
                5'(`TW_OFS_OWNA1): wb_dat_o <= {24'h0, ownAddrOne_r};
                5'(`TW_OFS_OWNA2): wb_dat_o <= {24'h0, own_address_two_reg};
                default:           wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // software registers; speed bits must be set before enabling
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            control_reg         <= `TW_CR_RST;
            ownAddrOne_r        <= `TW_OA_RST;
            own_address_two_reg <= `TW_OA_RST;
        end else if (wbHit && wb_we_i && wb_sel_i[0]) begin
            case (wb_adr_i)
                5'(`TW_OFS_CTRL):  control_reg         <= wb_dat_i[7:0];
                5'(`TW_OFS_OWNA1): ownAddrOne_r        <= wb_dat_i[7:0];
                5'(`TW_OFS_OWNA2): own_address_two_reg <= wb_dat_i[7:0];
                default:           control_reg         <= control_reg;
            endcase
        end
    end

    // bus busy regardless of participation
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            busy_r <= 1'b0;
        end else if (cond.start) begin
            busy_r <= 1'b1;
        end else if (cond.stop) begin
            busy_r <= 1'b0;
        end
    end

    // role: slave by default, master after own start, slave again on stop
    // master sequencing beyond the start is outside this block
    always_ff @(posedge clk) begin
        if (sys_rst || !enabled) begin
            controller_role_bit <= 1'b0;
        end else if (control_reg[`TW_CR_START] && !busy_r && !controller_role_bit) begin
            controller_role_bit <= 1'b1;
        end else if (cond.stop) begin
            controller_role_bit <= 1'b0;
        end
    end

    // slave engine: address compare, receive, transmit, acknowledge
    always_ff @(posedge clk) begin
        if (sys_rst || !enabled) begin
            state_r      <= TW_IDLE;
            shift_r      <= 8'h00;
            bitCnt_r     <= 4'h0;
            txMode_r     <= 1'b0;
            gcHit_r      <= 1'b0;
            hdrSeen_r    <= 1'b0;
            secondByte_r <= 1'b0;
            sdaDrv_r     <= 1'b0;
            txPend_r     <= 1'b0;
        end else if (cond.stop) begin
            state_r   <= TW_IDLE;
            sdaDrv_r  <= 1'b0;    // release lines
            hdrSeen_r <= 1'b0;
        end else if (cond.start) begin
            state_r  <= TW_ADDR;
            bitCnt_r <= 4'h0;
            sdaDrv_r <= 1'b0;
        end else begin
            case (state_r)
                TW_IDLE: state_r <= TW_IDLE;
                TW_ADDR, TW_RX: begin
                    if (cond.sclRise) begin
                        shift_r  <= {shift_r[6:0], cond.sda};
                        bitCnt_r <= bitCnt_r + 4'h1;
                    end else if (cond.sclFall && bitCnt_r == 4'h8) begin
                        bitCnt_r <= 4'h0;
                        if (state_r == TW_RX) begin
                            sdaDrv_r <= control_reg[`TW_CR_ACK];
                            state_r  <= TW_ACKR;
                        end else if (secondByte_r) begin
                            secondByte_r <= 1'b0;
                            if (shift_r == ownAddrOne_r) begin
                                sdaDrv_r <= control_reg[`TW_CR_ACK];
                                hdrSeen_r <= 1'b1;
                                txMode_r <= 1'b0;
                                state_r  <= TW_ACKA;
                            end else begin
                                state_r  <= TW_IDLE;
                            end
                        end else if (ten && shift_r[7:3] == `TW_HDR_PAT
                                 && shift_r[2:1] == own_address_two_reg[`TW_OA2_ADDHI +: 2]) begin
                            sdaDrv_r <= control_reg[`TW_CR_ACK];
                            if (shift_r[0] && hdrSeen_r) begin
                                txMode_r <= 1'b1;
                                state_r  <= TW_ACKA;
                            end else begin
                                secondByte_r <= 1'b1;
                                state_r      <= TW_ACKR;
                            end
                        end else if (!ten && shift_r[7:1] == ownAddrOne_r[7:1]) begin
                            sdaDrv_r <= control_reg[`TW_CR_ACK];
                            txMode_r <= shift_r[0];
                            gcHit_r  <= 1'b0;
                            state_r  <= TW_ACKA;
                        end else if (control_reg[`TW_CR_ENGC] && shift_r == `TW_GC_ADDR) begin
                            sdaDrv_r <= control_reg[`TW_CR_ACK];
                            txMode_r <= 1'b0;
                            gcHit_r  <= 1'b1;
                            state_r  <= TW_ACKA;
                        end else begin
                            state_r  <= TW_IDLE;
                        end
                    end
                end
                TW_ACKA, TW_ACKR: begin
                    // ninth clock done: release data, continue or wait in stretch
                    if (cond.sclFall) begin
                        sdaDrv_r <= 1'b0;
                        txPend_r <= txMode_r && !secondByte_r;
                        state_r  <= secondByte_r ? TW_ADDR : (txMode_r ? TW_TX : TW_RX);
                        shift_r  <= byte_buffer_reg;
                    end
                end
                TW_TX: begin
                    // shift out msb first on falling edges, clock held until written
                    if (!stretch_r && !txPend_r && bitCnt_r < 4'h8 && !cond.sclRise) begin
                        sdaDrv_r <= !shift_r[7];
                        if (cond.sclFall || bitCnt_r == 4'h0) begin
                            if (bitCnt_r != 4'h0 || cond.sclFall) begin
                                shift_r <= {shift_r[6:0], 1'b1};
                            end
                        end
                    end
                    if (cond.sclFall && !stretch_r && !txPend_r) begin
                        bitCnt_r <= bitCnt_r + 4'h1;
                        if (bitCnt_r == 4'h7) begin
                            sdaDrv_r <= 1'b0;
                            state_r  <= TW_ACKT;
                        end
                    end
                    // the byte to send is the one software writes now
                    if (wrData) begin
                        txPend_r <= 1'b0;
                        shift_r  <= wb_dat_i[7:0];
                    end
                end
                TW_ACKT: begin
                    // sample the master's acknowledge on the ninth rising edge
                    if (cond.sclRise) begin
                        bitCnt_r <= 4'h0;
                        shift_r  <= byte_buffer_reg;
                        txPend_r <= !cond.sda;
                        state_r  <= cond.sda ? TW_HOLD : TW_TX;
                    end
                end
                TW_HOLD: state_r <= TW_HOLD; // after nack: wait for stop or start
                default: state_r <= TW_IDLE;
            endcase
        end
    end

    // data register: captures received bytes, written by software for transmit
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            byte_buffer_reg <= 8'h00;
        end else if (wrData) begin
            byte_buffer_reg <= wb_dat_i[7:0];
        end else if (cond.sclFall && bitCnt_r == 4'h8 && (state_r == TW_RX
                     || state_r == TW_ADDR)) begin
            byte_buffer_reg <= shift_r;
        end
    end

    // event flags; hardware set wins over a software clear in the same cycle
    always_ff @(posedge clk) begin
        if (sys_rst || !enabled) begin
            own_address_match_flag    <= 1'b0;
            byte_done_flag            <= 1'b0;
            bus_end_seen_flag         <= 1'b0;
            misplaced_condition_error <= 1'b0;
            nack_failure_flag         <= 1'b0;
            st1Seen_r                 <= 1'b0;
        end else begin
            if (state_r inside {TW_ACKA} && cond.sclFall) begin
                own_address_match_flag <= 1'b1;
            end else if (rdSt1) begin
                own_address_match_flag <= 1'b0;
            end
            if ((state_r == TW_ACKR && !secondByte_r && cond.sclFall)
                || (state_r == TW_ACKT && cond.sclRise)) begin
                byte_done_flag <= 1'b1;
            end else if ((st1Seen_r && (rdData || wrData)) || cond.stop) begin
                byte_done_flag <= 1'b0;
            end
            if (cond.stop && state_r != TW_IDLE && !controller_role_bit) begin
                bus_end_seen_flag <= 1'b1;
            end else if (rdSt2) begin
                bus_end_seen_flag <= 1'b0;
            end
            // a condition in the first bit's high phase is a legal one
            if ((cond.start || cond.stop) && bitCnt_r > 4'h1
                && state_r inside {TW_ADDR, TW_RX, TW_TX}) begin
                misplaced_condition_error <= 1'b1;
            end else if (rdSt2) begin
                misplaced_condition_error <= 1'b0;
            end
            if (state_r == TW_ACKT && cond.sclRise && cond.sda) begin
                nack_failure_flag <= 1'b1;
            end else if (rdSt1) begin
                nack_failure_flag <= 1'b0;
            end
            if (rdSt1) begin
                st1Seen_r <= 1'b1;
            end else if (rdData || wrData) begin
                st1Seen_r <= 1'b0;
            end
        end
    end

    // summary event flag over all sources
    assign event_flag = own_address_match_flag | byte_done_flag | bus_end_seen_flag
                      | misplaced_condition_error | nack_failure_flag;

    // clock stretching while software owes an access; never in error cases
    always_ff @(posedge clk) begin
        if (sys_rst || !enabled) begin
            stretch_r <= 1'b0;
        end else if (misplaced_condition_error || nack_failure_flag
                     || state_r inside {TW_IDLE, TW_HOLD}) begin
            stretch_r <= 1'b0;
        end else if (own_address_match_flag || (byte_done_flag && state_r == TW_RX)) begin
            stretch_r <= !cond.sclRise;
        end else if (txPend_r && state_r == TW_TX) begin
            stretch_r <= stretch_r || cond.sclFall;
        end else begin
            stretch_r <= 1'b0;
        end
    end

    // registered pin drivers; disabled means the port logic owns the pins
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sdaOe     <= 1'b0;
            sclOe     <= 1'b0;
            pinsOwned <= 1'b0;
            irq       <= 1'b0;
        end else begin
            pinsOwned <= enabled;
            sdaOe     <= enabled && sdaDrv_r;
            sclOe     <= enabled && (stretch_r
                         || (controller_role_bit && halfTick && !sclOe));
            irq       <= event_flag && control_reg[`TW_CR_IRQ];
        end
    end
endmodule
`default_nettype wire

// ==== test/tw_iface_asserts.sv ====
// checker for tw_iface: bus answer timing and pin relations
// assumes it is bound onto tw_iface, one clock domain
`default_nettype none
module tw_iface_asserts (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic serial_clock_pin,
    input wire logic sdaOe,
    input wire logic sclOe,
    input wire logic pinsOwned,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // a taken request answers one cycle later
    wb_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack not one cycle after request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    port_pins_a: assert property (!pinsOwned |-> !sdaOe && !sclOe)
        else $error("pins driven while disabled");
    // stretching starts only in the low clock phase
    stretch_low_a: assert property ($rose(sclOe) |-> $past(!serial_clock_pin, 2))
        else $error("clock pulled outside low phase");
    data_low_a: assert property ($rose(sdaOe) |-> $past(!serial_clock_pin, 2))
        else $error("data pulled while clock high");
    // only software access ends a stretch
    stretch_end_a: assert property ($fell(sclOe) |-> $past(wb_cyc_i) || $past(wb_cyc_i, 2)
        || $past(wb_cyc_i, 3))
        else $error("stretch released without access");
    irq_clear_a: assert property ($fell(irq) |-> $past(wb_cyc_i) || $past(wb_cyc_i, 2)
        || $past(wb_cyc_i, 3))
        else $error("irq dropped without access");
    cover property (wb_ack_o);
    cover property ($rose(sclOe));
    cover property ($rose(irq));
endmodule
bind tw_iface tw_iface_asserts i_chk (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .serial_clock_pin(serial_clock_pin),
    .sdaOe(sdaOe), .sclOe(sclOe), .pinsOwned(pinsOwned), .irq(irq));
`default_nettype wire

// ==== test/tw_bus_master_model.sv ====
// far-side bus master model pulling both lines open drain
// assumes pull-ups on both lines: a released line reads high
`default_nettype none
module tw_bus_master_model (
    input  wire logic clk,
    input  wire logic sclLine,
    input  wire logic sdaLine,
    output logic      sclPull,
    output logic      sdaPull,
    output logic      hang
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sclPull = 0;
        sdaPull = 0;
        hang = 0;
    end
    // half of the 80 ns link period
    task automatic half(); repeat (5) @(posedge clk); endtask
    // release the clock and wait out a stretch, bounded
    task automatic clk_hi();
        int n;
        sclPull <= 0;
        n = 0;
        @(posedge clk);
        while (!sclLine && n < 20000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 20000) hang <= 1;
        half();
    endtask
    // data moves two cycles after the clock falls, so the order survives sync
    task automatic bit_out(input logic b, output logic r);
        sdaPull <= !b;
        half();
        clk_hi();
        r = sdaLine;
        sclPull <= 1;
        repeat (2) @(posedge clk);
    endtask
    task automatic start();
        sdaPull <= 0;
        half();
        clk_hi();
        sdaPull <= 1;
        half();
        sclPull <= 1;
        repeat (2) @(posedge clk);
    endtask
    task automatic stop();
        sdaPull <= 1;
        half();
        clk_hi();
        sdaPull <= 0;
        half();
    endtask
    task automatic byte_out(input logic [7:0] v, output logic a);
        logic r;
        for (int i = 7; i >= 0; i--) bit_out(v[i], r);
        bit_out(1'b1, r);
        a = !r;
    endtask
    task automatic byte_in(input logic a, output logic [7:0] v);
        logic r;
        for (int i = 0; i < 8; i++) begin
            bit_out(1'b1, r);
            v = {v[6:0], r};
        end
        bit_out(!a, r);
    endtask
endmodule
`default_nettype wire

// ==== test/tw_iface_tb.sv ====
// bench for tw_iface: wishbone tasks, master model on the lines
// assumes the checker and the master model are compiled first
`include "tw_cfg.svh"
`default_nettype none
module tw_iface_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, sys_rst, cyc, stb, we, ack, sdaOe, sclOe, owned, irq, mAck;
    logic [4:0]  adr;
    logic [31:0] datI, datO, q;
    logic [7:0]  d;
    wire logic   sclPull, sdaPull, hang;
    int          fails, samples_checked;
    wire logic   sclLine = !(sclPull | sclOe);
    wire logic   sdaLine = !(sdaPull | sdaOe);
    tw_iface i_dut (.clk(clk), .sys_rst(sys_rst), .wb_adr_i(adr), .wb_dat_i(datI),
        .wb_dat_o(datO), .wb_we_i(we), .wb_sel_i(4'hF), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_ack_o(ack), .serial_data_pin(sdaLine), .serial_clock_pin(sclLine),
        .sdaOe(sdaOe), .sclOe(sclOe), .pinsOwned(owned), .irq(irq));
    tw_bus_master_model i_mst (.clk(clk), .sclLine(sclLine), .sdaLine(sdaLine),
        .sclPull(sclPull), .sdaPull(sdaPull), .hang(hang));
    initial begin clk = 0; forever #4 clk = ~clk; end
    task automatic test_done();
        $display("checks %0d errors %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("[ERR] %s exp %h got %h", n, e, g);
            fails++;
        end
    endtask
    // one classic cycle, held until ack is sampled, bounded
    task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] v);
        int n;
        @(posedge clk);
        {cyc, stb, we, adr, datI} <= {1'b1, 1'b1, w, a, 24'h0, v};
        n = 0;
        do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 50);
        q = datO;
        cyc <= 0;
        stb <= 0;
        if (n >= 50) begin fails++; test_done(); end
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] e, input string n);
        wb(1'b0, a, 8'h00);
        chk(n, {24'h0, e}, q);
    endtask
    task automatic settle(); repeat (8) @(posedge clk); endtask
    task automatic t_setup();
        rd(`TW_OFS_CTRL, 8'h00, "ctrl rst");
        rd(5'h1C, 8'h00, "unmapped");
        chk("owned off", 0, owned);
        wb(1'b1, `TW_OFS_OWNA2, 8'h00);
        wb(1'b1, `TW_OFS_OWNA1, 8'hA4);
        wb(1'b1, `TW_OFS_CTRL, 8'h23);
        settle();
        chk("owned on", 1, owned);
    endtask
    task automatic t_write();
        i_mst.start();
        i_mst.byte_out(8'hA4, mAck);
        settle();
        chk("adr ack", 1, mAck);
        chk("adr stretch", 1, sclOe);
        chk("irq set", 1, irq);
        rd(`TW_OFS_STAT1, 8'h94, "sr1 match");
        settle();
        chk("adr release", 0, sclOe);
        rd(`TW_OFS_DATA, 8'hA4, "dir");
        i_mst.byte_out(8'h3C, mAck);
        settle();
        chk("rx stretch", 1, sclOe);
        rd(`TW_OFS_STAT1, 8'h98, "sr1 rx");
        rd(`TW_OFS_DATA, 8'h3C, "rx data");
        i_mst.stop();
        settle();
        rd(`TW_OFS_STAT2, 8'h04, "stop");
        rd(`TW_OFS_STAT1, 8'h00, "idle");
    endtask
    task automatic t_miss();
        i_mst.start();
        i_mst.byte_out(8'h20, mAck);
        chk("miss nack", 0, mAck);
        i_mst.stop();
        settle();
        wb(1'b0, `TW_OFS_STAT2, 8'h00);
        rd(`TW_OFS_STAT1, 8'h00, "miss idle");
    endtask
    task automatic t_read();
        i_mst.start();
        i_mst.byte_out(8'hA5, mAck);
        rd(`TW_OFS_STAT1, 8'hB4, "sr1 tx");
        wb(1'b1, `TW_OFS_DATA, 8'h96);
        i_mst.byte_in(1'b0, d);
        chk("tx data", 8'h96, d);
        settle();
        chk("no stretch", 0, sclOe);
        rd(`TW_OFS_STAT2, 8'h08, "nack");
        wb(1'b0, `TW_OFS_STAT1, 8'h00);
        rd(`TW_OFS_STAT2, 8'h00, "nack clr");
        i_mst.stop();
        settle();
        wb(1'b0, `TW_OFS_STAT2, 8'h00);
    endtask
    task automatic t_misplaced();
        i_mst.start();
        repeat (3) i_mst.bit_out(1'b1, mAck);
        i_mst.stop();
        settle();
        wb(1'b0, `TW_OFS_STAT2, 8'h00);
        chk("misplaced", 1, q[0]);
    endtask
    initial begin
        {sys_rst, cyc, stb, we, adr, datI} = {4'h8, 5'h00, 32'h0};
        fails = 0;
        samples_checked = 0;
        repeat (16) @(posedge clk);
        sys_rst <= 0;
        t_setup();
        t_write();
        t_miss();
        t_read();
        t_misplaced();
        chk("line hang", 0, hang);
        test_done();
    end
endmodule
`default_nettype wire
